// File: design/cwo_pkg.sv
package cwo_pkg;

    // Cache line states held by the local copy.
    typedef enum logic [2:0] {
        CWO_I,
        CWO_UC,
        CWO_SC,
        CWO_UD,
        CWO_SD
    } cwo_line_t;

    // Write address channel transaction kinds issued by the master.
    typedef enum logic [2:0] {
        CWO_W_NONE,
        CWO_W_UNIQUE,
        CWO_W_LINE_UNIQUE,
        CWO_W_BACK,
        CWO_W_CLEAN,
        CWO_W_EVICT_DATA,
        CWO_W_EVICT,
        CWO_W_NOSNOOP
    } cwo_wr_t;

    // Read address channel ownership requests issued for a store.
    typedef enum logic [1:0] {
        CWO_R_NONE,
        CWO_R_READ_UNIQUE,
        CWO_R_MAKE_UNIQUE,
        CWO_R_CLEAN_UNIQUE
    } cwo_rd_t;

    // Snoop kinds seen on the snoop address channel.
    typedef enum logic [2:0] {
        CWO_S_READ_ONCE,
        CWO_S_READ_CLEAN,
        CWO_S_READ_NSD,
        CWO_S_READ_SHARED,
        CWO_S_READ_UNIQUE,
        CWO_S_CLEAN_INVALID,
        CWO_S_MAKE_INVALID,
        CWO_S_CLEAN_SHARED
    } cwo_snp_t;

    // Width of the outstanding unique write counter.
    localparam int CWO_CNT_W = 4;
    localparam logic [CWO_CNT_W-1:0] CWO_CNT_RST = 4'h0;
    localparam logic [CWO_CNT_W-1:0] CWO_CNT_MAX = 4'hF;
    localparam logic [CWO_CNT_W-1:0] CWO_CNT_ONE = 4'h1;

endpackage

// File: design/cwo_seq.sv
// Notes on behaviour
// - No WriteBack, WriteClean, WriteEvict or Evict while a unique write is outstanding.
// - Snoops complete without any WriteBack, WriteClean, WriteEvict or Evict during unique writes.
// - Snoops still complete while a unique write is outstanding; WriteNoSnoop does not wait behind it.
// - Unique writes allowed only when snoops finish dataless or via snoop data channel.
// - Evict reports a line leaving the cache, on write address, with no data.
// - Evict only for addresses in a Shareable region.
// - Only a master with snoop filter support issues Evict.
// - A line may be dropped silently without an Evict.
// - Evict starts from UniqueClean or SharedClean and ends Invalid; a non-invalidating snoop hit in the same cycle leaves SharedClean.
// - The master sequenced second takes the first master's snoops while its store waits.
// - Invalidating snoop during pending ReadUnique or MakeUnique invalidates any local copy.
// - ReadUnique completes with data holding the first store; store only afterwards.
// - After an overlapped MakeUnique completes, the full-line store may proceed.
// - Invalidating snoop during pending CleanUnique: answer it, then invalidate locally.
// - After such a CleanUnique the partial store is not done; a new ReadUnique is.
// - ReadUnique may be issued instead of CleanUnique from the start.
// - Or after a granted CleanUnique, write changed bytes by partial WriteBack, keep no copy.
// - CleanUnique for a full-line store needs no retry; write the line on completion.
// - All copy-back writes and Evicts must finish before a unique write is issued.
`timescale 1ns/100ps
module cwo_seq
    import cwo_pkg::*;
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Static capabilities of this master.
    input wire logic i_snoop_filter_en,
    input wire logic i_snoop_data_ok,
    input wire logic i_use_read_unique,
    input wire logic i_partial_wb_en,
    input wire logic i_silent_drop_en,
    // Store request from the core.
    input wire logic i_store_req,
    input wire logic i_store_full,
    input wire logic i_store_shareable,
    // Write request from the cache controller.
    input wire logic i_wr_req,
    input wire cwo_wr_t i_wr_kind,
    input wire logic i_wr_shareable,
    // Write address channel handshake and write responses.
    input wire logic i_aw_ready,
    input wire logic i_b_done,
    input wire logic i_b_unique,
    // Read address channel handshake and completion.
    input wire logic i_ar_ready,
    input wire logic i_r_done,
    // Snoop address channel.
    input wire logic i_ac_valid,
    input wire cwo_snp_t i_ac_kind,
    input wire logic i_ac_hit,
    // Snoop response channel handshake.
    input wire logic i_cr_ready,
    // Write address issue.
    output logic o_aw_valid,
    output cwo_wr_t o_aw_kind,
    output logic o_aw_has_data,
    output logic o_wr_stall,
    // Read address issue.
    output logic o_ar_valid,
    output cwo_rd_t o_ar_kind,
    // Snoop answers.
    output logic o_ac_ready,
    output logic o_cr_valid,
    output logic o_cr_data,
    // Store progress, local line state and outstanding unique write count.
    output logic o_store_done,
    output logic o_store_lost,
    output cwo_line_t o_line_state,
    output logic [CWO_CNT_W-1:0] o_uniq_cnt
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_ISSUE,
        ST_RD_WAIT,
        ST_PWB_ISSUE,
        ST_DONE
    } cwo_st_t;

    cwo_st_t st_reg;
    cwo_rd_t rd_kind_reg;
    cwo_line_t line_reg;
    logic [CWO_CNT_W-1:0] uniq_cnt_reg;
    logic [CWO_CNT_W-1:0] cb_cnt_reg;
    logic lost_reg;
    logic aw_valid_reg;
    cwo_wr_t aw_kind_reg;
    logic ar_valid_reg;
    logic cr_valid_reg;
    logic cr_data_reg;
    logic done_reg;
    logic lost_out_reg;
    logic full_reg;

    logic is_uniq_req;
    logic is_cb_req;
    logic snp_inval;
    logic snp_take;
    logic aw_fire;
    logic wr_ok;
    logic uniq_issue;
    logic uniq_done;
    logic cb_issue;
    logic cb_done;
    logic pwb_fire;
    logic snp_lose;

    assign is_uniq_req = (i_wr_kind == CWO_W_UNIQUE) || (i_wr_kind == CWO_W_LINE_UNIQUE);
    assign is_cb_req = (i_wr_kind == CWO_W_BACK) || (i_wr_kind == CWO_W_CLEAN) ||
                       (i_wr_kind == CWO_W_EVICT_DATA) || (i_wr_kind == CWO_W_EVICT);
    assign snp_inval = (i_ac_kind == CWO_S_READ_UNIQUE) ||
                       (i_ac_kind == CWO_S_CLEAN_INVALID) ||
                       (i_ac_kind == CWO_S_MAKE_INVALID);
    // Snoops are taken whenever the response slot is free, never waiting on writes.
    assign snp_take = i_ac_valid && !cr_valid_reg;
    assign aw_fire = aw_valid_reg && i_aw_ready;
    assign pwb_fire = aw_fire && (st_reg == ST_PWB_ISSUE);
    assign uniq_issue = aw_fire && !pwb_fire &&
                        ((aw_kind_reg == CWO_W_UNIQUE) || (aw_kind_reg == CWO_W_LINE_UNIQUE));
    assign cb_issue = aw_fire && !uniq_issue;
    assign uniq_done = i_b_done && i_b_unique && (uniq_cnt_reg != CWO_CNT_RST);
    assign cb_done = i_b_done && !i_b_unique && (cb_cnt_reg != CWO_CNT_RST);

    // Decide whether the pending write may be issued this cycle.
    always_comb begin
        wr_ok = 1'b0;
        if (i_wr_req && !aw_valid_reg && (st_reg != ST_PWB_ISSUE)) begin
            if (is_uniq_req) begin
                wr_ok = (cb_cnt_reg == CWO_CNT_RST) && i_snoop_data_ok &&
                        (uniq_cnt_reg != CWO_CNT_MAX);
            end else if (is_cb_req) begin
                wr_ok = (uniq_cnt_reg == CWO_CNT_RST) && (cb_cnt_reg != CWO_CNT_MAX);
                if (i_wr_kind == CWO_W_EVICT) begin
                    wr_ok = wr_ok && i_wr_shareable && i_snoop_filter_en &&
                            ((line_reg == CWO_UC) || (line_reg == CWO_SC));
                end
            end else if (i_wr_kind == CWO_W_NOSNOOP) begin
                wr_ok = 1'b1;
            end
        end
    end

    // Write address channel request, held until the interconnect accepts it.
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            aw_valid_reg <= 1'b0;
            aw_kind_reg <= CWO_W_NONE;
        end else if (aw_fire) begin
            aw_valid_reg <= 1'b0;
        end else if (st_reg == ST_PWB_ISSUE && !aw_valid_reg && uniq_cnt_reg == CWO_CNT_RST) begin
            aw_valid_reg <= 1'b1;
            aw_kind_reg <= CWO_W_BACK;
        end else if (wr_ok) begin
            aw_valid_reg <= 1'b1;
            aw_kind_reg <= i_wr_kind;
        end
    end

    // Outstanding unique write count; issue and completion may coincide.
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            uniq_cnt_reg <= CWO_CNT_RST;
        end else if (uniq_issue && !uniq_done) begin
            uniq_cnt_reg <= uniq_cnt_reg + CWO_CNT_ONE;
        end else if (uniq_done && !uniq_issue) begin
            uniq_cnt_reg <= uniq_cnt_reg - CWO_CNT_ONE;
        end
    end

    // Outstanding copy-back and Evict count, also covering WriteNoSnoop issue slots.
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            cb_cnt_reg <= CWO_CNT_RST;
        end else if (cb_issue && !cb_done) begin
            cb_cnt_reg <= cb_cnt_reg + CWO_CNT_ONE;
        end else if (cb_done && !cb_issue) begin
            cb_cnt_reg <= cb_cnt_reg - CWO_CNT_ONE;
        end
    end

    // Store sequencer: ownership request, completion, then the store itself.
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            st_reg <= ST_IDLE;
            rd_kind_reg <= CWO_R_NONE;
            full_reg <= 1'b0;
        end else begin
            unique case (st_reg)
                ST_IDLE: begin
                    if (i_store_req && i_store_shareable) begin
                        full_reg <= i_store_full;
                        st_reg <= ST_RD_ISSUE;
                        if (line_reg == CWO_I || i_use_read_unique) begin
                            rd_kind_reg <= (i_store_full && line_reg == CWO_I) ?
                                           CWO_R_MAKE_UNIQUE : CWO_R_READ_UNIQUE;
                        end else begin
                            rd_kind_reg <= CWO_R_CLEAN_UNIQUE;
                        end
                    end
                end
                ST_RD_ISSUE: begin
                    if (ar_valid_reg && i_ar_ready) begin
                        st_reg <= ST_RD_WAIT;
                    end
                end
                ST_RD_WAIT: begin
                    if (i_r_done) begin
                        if (rd_kind_reg == CWO_R_CLEAN_UNIQUE && (lost_reg || snp_lose)
                            && !full_reg) begin
                            if (i_partial_wb_en) begin
                                st_reg <= ST_PWB_ISSUE;
                            end else begin
                                rd_kind_reg <= CWO_R_READ_UNIQUE;
                                st_reg <= ST_RD_ISSUE;
                            end
                        end else begin
                            st_reg <= ST_DONE;
                        end
                    end
                end
                ST_PWB_ISSUE: begin
                    if (pwb_fire) begin
                        // The bytes went to memory, so no local store follows.
                        st_reg <= ST_IDLE;
                    end
                end
                ST_DONE: begin
                    st_reg <= ST_IDLE;
                end
                default: begin
                    st_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // snoops from the first master arrive while our store waits
    assign snp_lose = snp_take && snp_inval && (st_reg inside {ST_RD_ISSUE, ST_RD_WAIT});

    // Lost-line marker for a pending CleanUnique; a snoop sets it over any clear.
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            lost_reg <= 1'b0;
        end else if (snp_lose && i_ac_hit) begin
            lost_reg <= 1'b1;
        end else if (st_reg == ST_IDLE) begin
            lost_reg <= 1'b0;
        end
    end

    // Read address channel request.
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            ar_valid_reg <= 1'b0;
        end else if (ar_valid_reg && i_ar_ready) begin
            ar_valid_reg <= 1'b0;
        end else if (st_reg == ST_RD_ISSUE) begin
            ar_valid_reg <= 1'b1;
        end
    end

    // Snoop answers; dirty data returns on the snoop data channel, never by a write.
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            cr_valid_reg <= 1'b0;
            cr_data_reg <= 1'b0;
        end else if (cr_valid_reg && i_cr_ready) begin
            cr_valid_reg <= 1'b0;
        end else if (snp_take) begin
            cr_valid_reg <= 1'b1;
            cr_data_reg <= i_ac_hit && (line_reg == CWO_UD || line_reg == CWO_SD) &&
                           (i_ac_kind != CWO_S_MAKE_INVALID);
        end
    end

    // Local line state updates from snoops, copy-back writes, Evicts, silent drops and stores.
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            line_reg <= CWO_I;
        end else if (snp_take && i_ac_hit && snp_inval) begin
            line_reg <= CWO_I;
        end else if (snp_take && i_ac_hit && line_reg != CWO_I) begin
            // Dirty data passed on a snoop leaves the copy clean and shared.
            line_reg <= CWO_SC;
        end else if (aw_fire && aw_kind_reg == CWO_W_CLEAN) begin
            line_reg <= CWO_UC;
        end else if (aw_fire && aw_kind_reg inside {[CWO_W_BACK:CWO_W_EVICT]}) begin
            // no copy kept after partial WriteBack
            line_reg <= CWO_I;
        end else if (i_silent_drop_en && st_reg == ST_IDLE && !i_store_req) begin
            line_reg <= CWO_I;
        end else if (st_reg == ST_DONE) begin
            line_reg <= CWO_UD;
        end
    end

    // Store outcome pulses.
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            done_reg <= 1'b0;
            lost_out_reg <= 1'b0;
        end else begin
            done_reg <= (st_reg == ST_DONE);
            lost_out_reg <= (st_reg == ST_RD_WAIT) && i_r_done &&
                            (rd_kind_reg == CWO_R_CLEAN_UNIQUE) && (lost_reg || snp_lose);
        end
    end

    assign o_aw_valid = aw_valid_reg;
    assign o_aw_kind = aw_kind_reg;
    assign o_aw_has_data = aw_valid_reg && (aw_kind_reg != CWO_W_EVICT);
    assign o_wr_stall = (uniq_cnt_reg != CWO_CNT_RST);
    assign o_ar_valid = ar_valid_reg;
    assign o_ar_kind = rd_kind_reg;
    assign o_ac_ready = !cr_valid_reg;
    assign o_cr_valid = cr_valid_reg;
    assign o_cr_data = cr_data_reg;
    assign o_store_done = done_reg;
    assign o_store_lost = lost_out_reg;
    assign o_line_state = line_reg;
    assign o_uniq_cnt = uniq_cnt_reg;

    // no copy-back issue while unique writes outstanding
    stall_cb_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (uniq_cnt_reg != CWO_CNT_RST) && aw_fire |-> !(aw_kind_reg inside
        {CWO_W_BACK, CWO_W_CLEAN, CWO_W_EVICT_DATA, CWO_W_EVICT}))
        else $error("Copy-back issued during unique write.");
    // unique write only after copy-backs drain
    drain_first_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $rose(aw_valid_reg) && (aw_kind_reg inside {CWO_W_UNIQUE, CWO_W_LINE_UNIQUE})
        |-> $past(cb_cnt_reg) == CWO_CNT_RST)
        else $error("Unique write issued with copy-backs pending.");
    evict_inval_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        aw_fire && aw_kind_reg == CWO_W_EVICT && !snp_take |=> line_reg == CWO_I)
        else $error("Line not Invalid after Evict.");
    evict_filter_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $rose(aw_valid_reg) && aw_kind_reg == CWO_W_EVICT |-> $past(i_snoop_filter_en))
        else $error("Evict without snoop filter.");
    snoop_inval_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        snp_take && i_ac_hit && snp_inval |=> line_reg == CWO_I)
        else $error("Copy kept after invalidating snoop.");
    // snoop answered next cycle regardless of writes
    snoop_prog_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        i_ac_valid && o_ac_ready |=> cr_valid_reg)
        else $error("Snoop not answered.");
    lost_nostore_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        lost_out_reg |-> !done_reg ##1 !done_reg)
        else $error("Store done after losing line.");
    // store completes only after read completion
    store_after_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $rose(done_reg) |-> $past(i_r_done, 2))
        else $error("Store done without completion.");

endmodule

// File: tb/cwo_icn_model.sv
`timescale 1ns/100ps
// Behavioural coherent interconnect that faces the store sequencer.
module cwo_icn_model
    import cwo_pkg::*;
(
    // Clock, reset and scenario controls.
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_slow,
    input wire logic i_hold_r,
    input wire logic i_hold_b,
    input wire logic i_snp_go,
    input wire cwo_snp_t i_snp_kind,
    input wire logic i_snp_hit,
    // Requests from the master.
    input wire logic i_aw_valid,
    input wire cwo_wr_t i_aw_kind,
    input wire logic i_ar_valid,
    input wire logic i_ac_ready,
    input wire logic i_cr_valid,
    // Answers to the master.
    output logic o_aw_ready,
    output logic o_b_done,
    output logic o_b_unique,
    output logic o_ar_ready,
    output logic o_r_done,
    output logic o_ac_valid,
    output cwo_snp_t o_ac_kind,
    output logic o_ac_hit,
    output logic o_cr_ready
);
    logic [1:0] tick_reg;
    logic r_pend_reg;
    logic go;
    logic b_q[$];

    // A slow run gives ready and read completion only on every fourth cycle; write responses and snoop requests are not slowed.
    assign go = !i_slow || tick_reg == 2'h3;

    // Every answer changes just after an edge; only the snoop request is held until taken, the rest pulse for one cycle.
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            {tick_reg, r_pend_reg, o_aw_ready, o_b_done, o_b_unique} <= '0;
            {o_ar_ready, o_r_done, o_ac_valid, o_ac_hit, o_cr_ready} <= '0;
            o_ac_kind <= CWO_S_READ_ONCE;
            b_q.delete();
        end else begin
            tick_reg <= tick_reg + 2'h1;
            o_aw_ready <= !o_aw_ready && i_aw_valid && go;
            o_ar_ready <= !o_ar_ready && i_ar_valid && go;
            o_cr_ready <= !o_cr_ready && i_cr_valid && go;
            if (i_aw_valid && o_aw_ready) begin
                b_q.push_back(i_aw_kind inside {CWO_W_UNIQUE, CWO_W_LINE_UNIQUE});
            end
            // The response tag toggles outside a response, so nothing may lean on it.
            if (!i_hold_b && b_q.size() > 0 && !o_b_done) begin
                o_b_done <= 1'b1;
                o_b_unique <= b_q.pop_front();
            end else begin
                o_b_done <= 1'b0;
                o_b_unique <= ~o_b_unique;
            end
            if (i_ar_valid && o_ar_ready) begin
                r_pend_reg <= 1'b1;
                o_r_done <= 1'b0;
            end else begin
                o_r_done <= r_pend_reg && !i_hold_r && go;
                r_pend_reg <= r_pend_reg && !(!i_hold_r && go);
            end
            if (o_ac_valid && i_ac_ready) begin
                o_ac_valid <= 1'b0;
                o_ac_kind <= cwo_snp_t'(~o_ac_kind);
                o_ac_hit <= ~o_ac_hit;
            end else if (i_snp_go && !o_ac_valid) begin
                o_ac_valid <= 1'b1;
                o_ac_kind <= i_snp_kind;
                o_ac_hit <= i_snp_hit;
            end
        end
    end
endmodule

// File: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
    import cwo_pkg::*;
    logic i_clk, i_reset_n, i_snoop_filter_en, i_snoop_data_ok, i_use_read_unique;
    logic i_partial_wb_en, i_silent_drop_en, i_store_req, i_store_full, i_store_shareable;
    logic i_wr_req, i_wr_shareable, i_aw_ready, i_b_done, i_b_unique, i_ar_ready, i_r_done;
    logic i_ac_valid, i_ac_hit, i_cr_ready, o_aw_valid, o_aw_has_data, o_wr_stall, o_ar_valid;
    logic o_ac_ready, o_cr_valid, o_cr_data, o_store_done, o_store_lost;
    logic slow, hold_r, hold_b, snp_go, snp_hit, bad;
    cwo_wr_t i_wr_kind, o_aw_kind;
    cwo_snp_t i_ac_kind, snp_kind;
    cwo_rd_t o_ar_kind;
    cwo_line_t o_line_state;
    logic [CWO_CNT_W-1:0] o_uniq_cnt;
    int err_count, n_checks;
    logic [7:0] q_aw[$], q_ar[$], q_cr[$], q_st[$];

    // Free running 125 MHz clock.
    always #4 i_clk = ~i_clk;

    cwo_seq cwo_seq_inst (.i_clk, .i_reset_n, .i_snoop_filter_en, .i_snoop_data_ok,
        .i_use_read_unique, .i_partial_wb_en, .i_silent_drop_en, .i_store_req, .i_store_full,
        .i_store_shareable, .i_wr_req, .i_wr_kind, .i_wr_shareable, .i_aw_ready, .i_b_done,
        .i_b_unique, .i_ar_ready, .i_r_done, .i_ac_valid, .i_ac_kind, .i_ac_hit, .i_cr_ready,
        .o_aw_valid, .o_aw_kind, .o_aw_has_data, .o_wr_stall, .o_ar_valid, .o_ar_kind,
        .o_ac_ready, .o_cr_valid, .o_cr_data, .o_store_done, .o_store_lost, .o_line_state,
        .o_uniq_cnt);

    cwo_icn_model cwo_icn_model_inst (.i_clk, .i_reset_n, .i_slow(slow), .i_hold_r(hold_r),
        .i_hold_b(hold_b), .i_snp_go(snp_go), .i_snp_kind(snp_kind), .i_snp_hit(snp_hit),
        .i_aw_valid(o_aw_valid), .i_aw_kind(o_aw_kind), .i_ar_valid(o_ar_valid),
        .i_ac_ready(o_ac_ready), .i_cr_valid(o_cr_valid), .o_aw_ready(i_aw_ready),
        .o_b_done(i_b_done), .o_b_unique(i_b_unique), .o_ar_ready(i_ar_ready),
        .o_r_done(i_r_done), .o_ac_valid(i_ac_valid), .o_ac_kind(i_ac_kind),
        .o_ac_hit(i_ac_hit), .o_cr_ready(i_cr_ready));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t %s: seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Takes the oldest note; a result with no note pending is itself a mismatch.
    task automatic take(ref logic [7:0] q[$], input logic [7:0] seen, input string what);
        if (q.size() == 0) chk(8'h00, 8'h01, {"unexpected ", what});
        else chk(seen, q.pop_front(), what);
    endtask

    function automatic logic sig(input int sel);
        case (sel)
            0: return o_aw_valid;
            1: return o_ar_valid;
            2: return o_store_done | o_store_lost;
            default: return o_cr_valid;
        endcase
    endfunction

    // Bounded wait, sampled just after the edge so that the edge's updates have landed.
    task automatic wt(input int sel, input logic v);
        int n;
        n = 0;
        do begin
            @(posedge i_clk);
            #1;
            n++;
        end while (sig(sel) !== v && n < 300);
        chk(8'(n < 300), 8'h01, "wait for handshake");
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    // Write request; a refused one must leave the write address idle for 20 cycles.
    task automatic wr(input cwo_wr_t k, input logic sh, input logic ok);
        if (ok) q_aw.push_back(8'(k));
        @(posedge i_clk);
        i_wr_req <= 1'b1;
        i_wr_kind <= k;
        i_wr_shareable <= sh;
        bad = 1'b0;
        if (ok) begin
            wt(0, 1'b1);
            chk(8'(o_aw_has_data), 8'(k != CWO_W_EVICT), "write data flag");
        end else begin
            repeat (20) begin
                @(posedge i_clk);
                #1;
                bad = bad | o_aw_valid;
            end
            chk(8'(bad), 8'h00, "refused write issued");
        end
        @(posedge i_clk);
        i_wr_req <= 1'b0;
        if (ok) wt(0, 1'b0);
    endtask

    // Store request with the expected ownership read and outcome {lost, done}.
    task automatic st(input logic full, input cwo_rd_t k, input logic [1:0] res);
        q_ar.push_back(8'(k));
        q_st.push_back(8'(res));
        slow <= 1'($urandom);
        @(posedge i_clk);
        i_store_req <= 1'b1;
        i_store_full <= full;
        i_store_shareable <= 1'b1;
        wt(1, 1'b1);
        @(posedge i_clk);
        i_store_req <= 1'b0;
    endtask

    task automatic snp(input cwo_snp_t k, input logic hit, input logic d);
        q_cr.push_back(8'(d));
        cyc($urandom_range(1, 4));
        snp_go <= 1'b1;
        snp_kind <= k;
        snp_hit <= hit;
        @(posedge i_clk);
        snp_go <= 1'b0;
        wt(3, 1'b1);
        wt(3, 1'b0);
    endtask

    task automatic line_is(input cwo_line_t s);
        cyc(6);
        #1;
        chk(8'(o_line_state), 8'(s), "line state");
    endtask

    // Full store from Invalid ends Dirty; a cleaning write then leaves it UniqueClean.
    task automatic mk_ud;
        st(1'b1, CWO_R_MAKE_UNIQUE, 2'b01);
        wt(2, 1'b1);
        line_is(CWO_UD);
    endtask

    task automatic mk_uc;
        wr(CWO_W_CLEAN, 1'b1, 1'b1);
        line_is(CWO_UC);
    endtask

    // Result monitor: each observed transfer consumes the oldest matching note.
    always @(posedge i_clk) begin
        if (i_reset_n) begin
            if (o_aw_valid && i_aw_ready) take(q_aw, 8'(o_aw_kind), "write kind");
            if (o_ar_valid && i_ar_ready) take(q_ar, 8'(o_ar_kind), "read kind");
            if (o_cr_valid && i_cr_ready) take(q_cr, 8'(o_cr_data), "snoop data");
            if (o_store_done | o_store_lost) begin
                take(q_st, 8'({o_store_lost, o_store_done}), "store outcome");
            end
        end
    end

    // Watchdog for a hung handshake.
    initial begin
        #(400000);
        err_count++;
        summarize();
    end

    initial begin
        {i_clk, i_reset_n, i_use_read_unique, i_partial_wb_en, i_silent_drop_en} = '0;
        {i_store_req, i_store_full, i_store_shareable, i_wr_req, i_wr_shareable} = '0;
        {slow, hold_r, hold_b, snp_go, snp_hit, bad} = '0;
        {i_snoop_filter_en, i_snoop_data_ok} = 2'h3;
        i_wr_kind = CWO_W_NONE;
        snp_kind = CWO_S_READ_ONCE;
        void'($urandom(32'h1885));
        cyc(5);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
        #1;
        chk(8'({o_aw_valid, o_ar_valid, o_cr_valid, o_ac_ready}), 8'h01, "reset outputs");
        chk(8'(o_uniq_cnt), 8'h00, "reset count");
        // Overlapped full-line store: a miss snoop meanwhile, then the store lands.
        hold_r <= 1'b1;
        st(1'b1, CWO_R_MAKE_UNIQUE, 2'b01);
        snp(CWO_S_MAKE_INVALID, 1'b0, 1'b0);
        hold_r <= 1'b0;
        wt(2, 1'b1);
        line_is(CWO_UD);
        // Evict needs a shareable line, a snoop filter and a clean line.
        mk_uc();
        wr(CWO_W_EVICT, 1'b0, 1'b0);
        i_snoop_filter_en <= 1'b0;
        wr(CWO_W_EVICT, 1'b1, 1'b0);
        i_snoop_filter_en <= 1'b1;
        wr(CWO_W_EVICT, 1'b1, 1'b1);
        line_is(CWO_I);
        // Partial store forced to ReadUnique from a clean copy.
        mk_ud();
        mk_uc();
        i_use_read_unique <= 1'b1;
        st(1'b0, CWO_R_READ_UNIQUE, 2'b01);
        wt(2, 1'b1);
        i_use_read_unique <= 1'b0;
        line_is(CWO_UD);
        // CleanUnique loses the line to a snoop, then retries with ReadUnique.
        mk_uc();
        hold_r <= 1'b1;
        st(1'b0, CWO_R_CLEAN_UNIQUE, 2'b10);
        snp(CWO_S_CLEAN_INVALID, 1'b1, 1'b0);
        line_is(CWO_I);
        q_ar.push_back(8'(CWO_R_READ_UNIQUE));
        q_st.push_back(8'h01);
        hold_r <= 1'b0;
        wt(2, 1'b1);
        wt(2, 1'b1);
        line_is(CWO_UD);
        // Lost CleanUnique resolved by a partial WriteBack that keeps no copy.
        mk_uc();
        i_partial_wb_en <= 1'b1;
        hold_r <= 1'b1;
        st(1'b0, CWO_R_CLEAN_UNIQUE, 2'b10);
        snp(CWO_S_READ_UNIQUE, 1'b1, 1'b0);
        q_aw.push_back(8'(CWO_W_BACK));
        hold_r <= 1'b0;
        wt(2, 1'b1);
        wt(0, 1'b1);
        wt(0, 1'b0);
        i_partial_wb_en <= 1'b0;
        line_is(CWO_I);
        // Unique writes wait for copy-backs and then block every copy-back kind.
        hold_b <= 1'b1;
        wr(CWO_W_BACK, 1'b1, 1'b1);
        wr(CWO_W_UNIQUE, 1'b1, 1'b0);
        hold_b <= 1'b0;
        cyc(4);
        hold_b <= 1'b1;
        wr(CWO_W_UNIQUE, 1'b1, 1'b1);
        chk(8'({o_wr_stall, o_uniq_cnt}), 8'h11, "unique count");
        for (int i = 0; i < 4; i++) begin
            wr(cwo_wr_t'(3 + i), 1'b1, 1'b0);
        end
        snp(CWO_S_CLEAN_INVALID, 1'b0, 1'b0);
        snp(CWO_S_READ_ONCE, 1'b0, 1'b0);
        hold_b <= 1'b0;
        cyc(8);
        #1;
        chk(8'({o_wr_stall, o_uniq_cnt}), 8'h00, "unique count drained");
        i_snoop_data_ok <= 1'b0;
        wr(CWO_W_LINE_UNIQUE, 1'b1, 1'b0);
        i_snoop_data_ok <= 1'b1;
        wr(CWO_W_LINE_UNIQUE, 1'b1, 1'b1);
        // A clean line may also be dropped with no Evict at all.
        mk_ud();
        mk_uc();
        i_silent_drop_en <= 1'b1;
        line_is(CWO_I);
        i_silent_drop_en <= 1'b0;
        cyc(4);
        chk(8'(q_aw.size() + q_ar.size() + q_cr.size() + q_st.size()), 8'h00, "notes left");
        summarize();
    end
endmodule
